/* File: design/irq_ctrl_defines.svh */
// Offsets, field positions, reset values and codes of the interrupt controller.
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH
`define OFS_POLARITY 16'h3000
`define OFS_CLEAR 16'h3004
`define OFS_ENABLE0 16'h3008
`define OFS_ENABLE1 16'h300C
`define OFS_FLAGS0 16'h3010
`define OFS_FLAGS1 16'h3014
`define OFS_CUSTOM 16'h209C
`define OFS_EXTCFG_LO 16'h3020
`define OFS_EXTCFG_HI 16'h3024
`define OFS_ROUTE 16'h3028
`define OFS_EXTSTAT 16'h302C
`define RST_ENABLE 32'h0000_2000
`define RST_CUSTOM 32'h0000_0010
`define RST_POLARITY 1'h0
`define SOURCE_MASK 32'hAF83_BFFF
`define MEAS_MSB 8
`define CUSTOM_LSB 9
`define CUSTOM_MSB 12
`define BOOT_BIT 13
`define SEQ_END_BIT 15
`define TMO_DONE_BIT 16
`define TMO_ERR_BIT 17
`define FIFO_LSB 23
`define FIFO_MSB 27
`define OUTLIER_BIT 29
`define COLLIDE_BIT 31
`define ROUTE_NONE 2'h0
`define ROUTE_A 2'h1
`define ROUTE_B 2'h2
`define ROUTE_C 2'h3
`define PIN_FIRST_A 0
`define PIN_FIRST_B 3
`define PIN_FIRST_C 6
`define PIN_SECOND_A 4
`define PIN_SECOND_B 7
`endif

/* File: design/irq_ctrl_pkg.sv */
// Types shared by the interrupt controller.
package irq_ctrl_pkg;
  typedef struct packed {
    logic [1:0] second;
    logic [1:0] first;
  } route_t;
  typedef struct packed {
    logic low;
    logic high;
    logic either;
    logic fall;
    logic rise;
  } ext_mode_t;
endpackage : irq_ctrl_pkg

/* File: design/two_line_interrupt_controller.sv */
// Two-line interrupt controller with external event detectors.
// Summary of operation
// [RULE1] Two blocks, each with enable mask and flags; polarity and clear shared.
// [RULE2] A flag sets only when its source is enabled in that block.
// [RULE3] First line goes to pin 0, 3 or 6; second to pin 4 or 7.
// [RULE4] Software picks rising or falling edge signalling via the polarity register.
// [RULE5] An enabled event moves the routed pin from idle to active level.
// [RULE6] Writing a bit position to the clear register clears that pending flag.
// [RULE7] Four custom sources are enabled by mask bits 12 down to 9.
// [RULE8] Custom events come only from sequencer writes; bus writes are ignored.
// [RULE9] Eight external detectors, each any mix of edge and level modes.
// [RULE10] Edge modes give one pulse on rising, falling or either transition.
// [RULE11] Level modes hold the line while the input stays at the level.
// [RULE12] An external detector hit raises wake while in hibernate.
// [RULE13] Flags 0 to 3: converter, transform, averaging filter, temperature results.
// [RULE14] Flags 4 to 6 limit failures; 7 mean; 8 variance.
// [RULE15] Flag 13 boot load done; flag 15 sequence ended.
// [RULE16] Flag 16 sequencer timeout finished; 17 timeout command error.
// [RULE17] Flags 23 to 27: FIFO full, empty, threshold, overflow, underflow.
// [RULE18] Flag 29 reports a measurement outlier.
// [RULE19] A sequence request while busy sets flag 31 and is dropped.
// [RULE20] Polarity 0 means negative edge, 1 positive; reset is negative.
// [RULE21] Clear register is write-only; ones clear, zeros do nothing.
// [RULE22] Unassigned flag and enable bits read zero and never signal.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"
module two_line_interrupt_controller #(
  parameter int NUM_EXT = 8
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port.
  input wire logic [15:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Internal event pulses.
  input wire logic [8:0] MEAS_EVENTS,
  input wire logic BOOT_DONE,
  input wire logic SEQ_END,
  input wire logic TMO_DONE,
  input wire logic TMO_ERR,
  input wire logic [4:0] FIFO_EVENTS,
  input wire logic OUTLIER,
  // Sequencer side.
  input wire logic SEQ_REQ,
  input wire logic SEQ_BUSY,
  input wire logic SEQ_TRIG_WR,
  input wire logic [31:0] SEQ_TRIG_DATA,
  output logic SEQ_START,
  // External detectors and wake.
  input wire logic [NUM_EXT-1:0] EXT_IN,
  input wire logic HIBERNATE,
  output logic [NUM_EXT-1:0] EXT_IRQ,
  output logic WAKE,
  // Interrupt lines and general pins.
  output logic IRQ_LINE_FIRST,
  output logic IRQ_LINE_SECOND,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE
);

  // The configuration words pack exactly eight detector fields.
  if (NUM_EXT != 8)
  begin : g_bad_num_ext
    $error("Detector configuration registers serve exactly eight detectors.");
  end

  // Any chosen mode that matches raises the detector output.
  function automatic logic ext_hit(input irq_ctrl_pkg::ext_mode_t m,
                                   input logic now, input logic prev);
    logic rise_e;
    logic fall_e;
    rise_e = now & ~prev;
    fall_e = ~now & prev;
    ext_hit = (m.rise & rise_e) | (m.fall & fall_e) |
              (m.either & (rise_e | fall_e)) |
              (m.high & now) | (m.low & ~now);
  endfunction : ext_hit

  // Next flag value: a clear and a set in one cycle leave the flag set.
  function automatic logic [31:0] flag_next(input logic [31:0] cur,
                                            input logic [31:0] clr,
                                            input logic [31:0] set);
    flag_next = ((cur & ~clr) | set) & `SOURCE_MASK;
  endfunction : flag_next

  logic polarity_select_bit_r;
  logic [31:0] irq_enable_mask0_r;
  logic [31:0] irq_enable_mask1_r;
  logic [31:0] irq_pending_flags0_r;
  logic [31:0] irq_pending_flags1_r;
  logic [31:0] custom_event_trigger_r;
  logic [39:0] ext_cfg_r;
  irq_ctrl_pkg::route_t route_r;
  logic [31:0] rdata_r;
  logic [NUM_EXT-1:0] ext_meta_r;
  logic [NUM_EXT-1:0] ext_sync_r;
  logic [NUM_EXT-1:0] ext_prev_r;
  logic [NUM_EXT-1:0] ext_irq_r;
  logic wake_r;
  logic seq_start_r;
  logic line_first_r;
  logic line_second_r;
  logic [7:0] pin_out_r;
  logic [7:0] pin_oe_r;

  // Register decode.
  wire wr_pol = WR && (ADDR == `OFS_POLARITY);
  wire wr_clr = WR && (ADDR == `OFS_CLEAR);
  wire wr_en0 = WR && (ADDR == `OFS_ENABLE0);
  wire wr_en1 = WR && (ADDR == `OFS_ENABLE1);
  wire wr_cfg_lo = WR && (ADDR == `OFS_EXTCFG_LO);
  wire wr_cfg_hi = WR && (ADDR == `OFS_EXTCFG_HI);
  wire wr_route = WR && (ADDR == `OFS_ROUTE);

  // Clear strobe acts for one cycle and is never stored.
  wire [31:0] clear_bits = wr_clr ? WDATA : 32'h0000_0000; // [RULE6] [RULE21]

  // Custom events come from the sequencer only; the register port has no path.
  wire [3:0] custom_events = SEQ_TRIG_WR ?
         SEQ_TRIG_DATA[`CUSTOM_MSB:`CUSTOM_LSB] : 4'h0; // [RULE8]

  // A request arriving while a sequence runs is dropped and reported.
  wire collide = SEQ_REQ & SEQ_BUSY; // [RULE19]
  wire seq_start_nxt = SEQ_REQ & ~SEQ_BUSY; // [RULE19]

  // Source vector laid out by flag position.
  logic [31:0] event_vec;
  always_comb
  begin
    event_vec = 32'h0000_0000;
    event_vec[3:0] = MEAS_EVENTS[3:0]; // [RULE13]
    event_vec[`MEAS_MSB:4] = MEAS_EVENTS[8:4]; // [RULE14]
    event_vec[`CUSTOM_MSB:`CUSTOM_LSB] = custom_events; // [RULE7]
    event_vec[`BOOT_BIT] = BOOT_DONE; // [RULE15]
    event_vec[`SEQ_END_BIT] = SEQ_END; // [RULE15]
    event_vec[`TMO_DONE_BIT] = TMO_DONE; // [RULE16]
    event_vec[`TMO_ERR_BIT] = TMO_ERR; // [RULE16]
    event_vec[`FIFO_MSB:`FIFO_LSB] = FIFO_EVENTS; // [RULE17]
    event_vec[`OUTLIER_BIT] = OUTLIER; // [RULE18]
    event_vec[`COLLIDE_BIT] = collide; // [RULE19]
  end

  // Each block only records what its own mask lets through.
  wire [31:0] set0 = event_vec & irq_enable_mask0_r; // [RULE2]
  wire [31:0] set1 = event_vec & irq_enable_mask1_r; // [RULE2]
  wire [31:0] flags0_nxt = flag_next(irq_pending_flags0_r, clear_bits, set0); // [RULE1]
  wire [31:0] flags1_nxt = flag_next(irq_pending_flags1_r, clear_bits, set1); // [RULE1]
  wire [31:0] en_mask_nxt = WDATA & `SOURCE_MASK; // [RULE22]
  wire [31:0] custom_nxt = custom_event_trigger_r |
         {19'h0, custom_events, 9'h000};

  // The line sits at the idle level and moves to the active level while a flag
  // is pending, so the host sees the edge chosen by polarity.
  wire any0 = |irq_pending_flags0_r;
  wire any1 = |irq_pending_flags1_r;
  wire line_first_nxt = polarity_select_bit_r ? any0 : ~any0; // [RULE4] [RULE5] [RULE20]
  wire line_second_nxt = polarity_select_bit_r ? any1 : ~any1; // [RULE4] [RULE5] [RULE20]

  // Pin routing; an unrouted pin is left undriven.
  logic [7:0] pin_out_nxt;
  logic [7:0] pin_oe_nxt;
  always_comb
  begin
    pin_out_nxt = 8'h00;
    pin_oe_nxt = 8'h00;
    unique case (route_r.first) // [RULE3]
      `ROUTE_A: pin_oe_nxt[`PIN_FIRST_A] = 1'b1;
      `ROUTE_B: pin_oe_nxt[`PIN_FIRST_B] = 1'b1;
      `ROUTE_C: pin_oe_nxt[`PIN_FIRST_C] = 1'b1;
      `ROUTE_NONE: pin_oe_nxt = pin_oe_nxt;
    endcase
    unique case (route_r.second) // [RULE3]
      `ROUTE_A: pin_oe_nxt[`PIN_SECOND_A] = 1'b1;
      `ROUTE_B: pin_oe_nxt[`PIN_SECOND_B] = 1'b1;
      default: pin_oe_nxt = pin_oe_nxt;
    endcase
    pin_out_nxt[`PIN_FIRST_A] = line_first_nxt;
    pin_out_nxt[`PIN_FIRST_B] = line_first_nxt;
    pin_out_nxt[`PIN_FIRST_C] = line_first_nxt;
    pin_out_nxt[`PIN_SECOND_A] = line_second_nxt;
    pin_out_nxt[`PIN_SECOND_B] = line_second_nxt;
    pin_out_nxt = pin_out_nxt & pin_oe_nxt;
  end

  // External detectors read the second synchroniser stage and its one-cycle delayed copy only.
  logic [NUM_EXT-1:0] ext_irq_nxt;
  always_comb
  begin
    ext_irq_nxt = '0;
    for (int i = 0; i < NUM_EXT; i++)
    begin
      ext_irq_nxt[i] = ext_hit(ext_cfg_r[i*5 +: 5],
                               ext_sync_r[i], ext_prev_r[i]); // [RULE9] [RULE10] [RULE11]
    end
  end
  wire wake_nxt = HIBERNATE & (|ext_irq_nxt); // [RULE12]

  // Read selection.
  logic [31:0] rd_sel;
  always_comb
  begin
    rd_sel = 32'h0000_0000;
    unique case (ADDR)
      `OFS_POLARITY: rd_sel = {31'h0, polarity_select_bit_r};
      `OFS_ENABLE0: rd_sel = irq_enable_mask0_r;
      `OFS_ENABLE1: rd_sel = irq_enable_mask1_r;
      `OFS_FLAGS0: rd_sel = irq_pending_flags0_r;
      `OFS_FLAGS1: rd_sel = irq_pending_flags1_r;
      `OFS_CUSTOM: rd_sel = custom_event_trigger_r;
      `OFS_EXTCFG_LO: rd_sel = {3'h0, ext_cfg_r[19:15], 3'h0, ext_cfg_r[14:10],
                                3'h0, ext_cfg_r[9:5], 3'h0, ext_cfg_r[4:0]};
      `OFS_EXTCFG_HI: rd_sel = {3'h0, ext_cfg_r[39:35], 3'h0, ext_cfg_r[34:30],
                                3'h0, ext_cfg_r[29:25], 3'h0, ext_cfg_r[24:20]};
      `OFS_ROUTE: rd_sel = {28'h0, route_r};
      `OFS_EXTSTAT: rd_sel = {24'h0, ext_irq_r};
      default: rd_sel = 32'h0000_0000; // Clear register and holes read zero.
    endcase
  end
  wire [31:0] rdata_nxt = RD ? rd_sel : 32'h0000_0000;

  // Configuration registers.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      polarity_select_bit_r <= `RST_POLARITY; // [RULE20]
      irq_enable_mask0_r <= `RST_ENABLE;
      irq_enable_mask1_r <= `RST_ENABLE;
      route_r <= '0;
      ext_cfg_r <= '0;
    end
    else
    begin
      if (wr_pol)
        polarity_select_bit_r <= WDATA[0]; // [RULE4]
      if (wr_en0)
        irq_enable_mask0_r <= en_mask_nxt; // [RULE1] [RULE7]
      if (wr_en1)
        irq_enable_mask1_r <= en_mask_nxt; // [RULE1] [RULE7]
      if (wr_route)
        route_r <= WDATA[3:0];
      if (wr_cfg_lo)
        ext_cfg_r[19:0] <= {WDATA[28:24], WDATA[20:16], WDATA[12:8], WDATA[4:0]};
      if (wr_cfg_hi)
        ext_cfg_r[39:20] <= {WDATA[28:24], WDATA[20:16], WDATA[12:8], WDATA[4:0]};
    end
  end

  // Flags and custom trigger record.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      irq_pending_flags0_r <= 32'h0000_0000;
      irq_pending_flags1_r <= 32'h0000_0000;
      custom_event_trigger_r <= `RST_CUSTOM;
    end
    else
    begin
      irq_pending_flags0_r <= flags0_nxt;
      irq_pending_flags1_r <= flags1_nxt;
      custom_event_trigger_r <= custom_nxt; // [RULE8]
    end
  end

  // Synchronisers and detector outputs.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ext_meta_r <= '0;
      ext_sync_r <= '0;
      ext_prev_r <= '0;
      ext_irq_r <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      ext_meta_r <= EXT_IN;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      ext_irq_r <= ext_irq_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Output registers; lines idle high after reset since polarity is negative.
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rdata_r <= 32'h0000_0000;
      seq_start_r <= 1'b0;
      line_first_r <= 1'b1;
      line_second_r <= 1'b1;
      pin_out_r <= 8'h00;
      pin_oe_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      seq_start_r <= seq_start_nxt;
      line_first_r <= line_first_nxt;
      line_second_r <= line_second_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign SEQ_START = seq_start_r;
  assign EXT_IRQ = ext_irq_r;
  assign WAKE = wake_r;
  assign IRQ_LINE_FIRST = line_first_r;
  assign IRQ_LINE_SECOND = line_second_r;
  assign PIN_OUT = pin_out_r;
  assign PIN_OE = pin_oe_r;

  // Checks.
  enabled_set_a: assert property ( // [RULE2]
    @(posedge REF_CLK) disable iff (RST)
    $rose(irq_pending_flags0_r[0]) |-> $past(irq_enable_mask0_r[0]))
    else $error("Flag set for a disabled source.");

  clear_wins_a: assert property ( // [RULE6]
    @(posedge REF_CLK) disable iff (RST)
    (wr_clr && WDATA[15] && !set1[15]) |=> !irq_pending_flags1_r[15])
    else $error("Clear did not drop the flag.");

  set_beats_clear_a: assert property ( // [RULE1]
    @(posedge REF_CLK) disable iff (RST)
    (wr_clr && WDATA[13] && set0[13]) |=> irq_pending_flags0_r[13])
    else $error("Event lost under a clear.");

  zero_clear_a: assert property ( // [RULE21]
    @(posedge REF_CLK) disable iff (RST)
    (wr_clr && !WDATA[0] && irq_pending_flags0_r[0]) |=> irq_pending_flags0_r[0])
    else $error("Writing zero cleared a flag.");

  unused_bits_a: assert property ( // [RULE22]
    @(posedge REF_CLK) disable iff (RST)
    ((irq_pending_flags0_r | irq_pending_flags1_r |
      irq_enable_mask0_r | irq_enable_mask1_r) & ~`SOURCE_MASK) == 32'h0)
    else $error("Unassigned bit is set.");

  line_level_a: assert property ( // [RULE5]
    @(posedge REF_CLK) disable iff (RST)
    (|irq_pending_flags0_r) ##1 (|irq_pending_flags0_r) |->
    (IRQ_LINE_FIRST == polarity_select_bit_r))
    else $error("First line not at active level.");

  pin_route_a: assert property ( // [RULE3]
    @(posedge REF_CLK) disable iff (RST)
    (route_r.first == `ROUTE_B) ##1 (route_r.first == `ROUTE_B) |->
    PIN_OE[`PIN_FIRST_B] && (PIN_OUT[`PIN_FIRST_B] == IRQ_LINE_FIRST))
    else $error("First line not on its routed pin.");

  bus_custom_a: assert property ( // [RULE8]
    @(posedge REF_CLK) disable iff (RST)
    (!SEQ_TRIG_WR) |=> $stable(custom_event_trigger_r))
    else $error("Custom trigger changed without the sequencer.");

  collide_a: assert property ( // [RULE19]
    @(posedge REF_CLK) disable iff (RST)
    (SEQ_REQ && SEQ_BUSY && irq_enable_mask0_r[`COLLIDE_BIT]) |=>
    (irq_pending_flags0_r[`COLLIDE_BIT] && !SEQ_START))
    else $error("Late sequence request not dropped and flagged.");

  rise_pulse_a: assert property ( // [RULE10]
    @(posedge REF_CLK) disable iff (RST)
    (ext_cfg_r[4:0] == 5'h01) ##1 $rose(ext_sync_r[0]) ##1 (ext_cfg_r[4:0] == 5'h01)
    |-> EXT_IRQ[0] ##1 !EXT_IRQ[0])
    else $error("Rising edge did not give one pulse.");

  level_hold_a: assert property ( // [RULE11]
    @(posedge REF_CLK) disable iff (RST)
    (ext_cfg_r[9:5] == 5'h08 && ext_sync_r[1]) ##1 (ext_cfg_r[9:5] == 5'h08)
    |-> EXT_IRQ[1])
    else $error("High level not held.");

  wake_a: assert property ( // [RULE12]
    @(posedge REF_CLK) disable iff (RST)
    (HIBERNATE && (|ext_irq_nxt)) |=> WAKE)
    else $error("No wake in hibernate.");

endmodule : two_line_interrupt_controller

/* File: tb/irq_host_model.sv */
// Host-side model that counts interrupt edges seen on its routed input pin.
`timescale 1ns/1ps
module irq_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Watched pin and expected active level.
  input wire logic pin,
  input wire logic pol,
  // Number of active transitions seen.
  output logic [15:0] edges
);
  logic pin_d;

  // Only a move onto the active level counts, so a polarity change with no flag pending never alerts the host.
  always_ff @(posedge clk)
  begin
    pin_d <= pin;
    if (rst)
      edges <= 16'h0000;
    else if (pin !== pin_d && pin === pol)
      edges <= edges + 16'h0001;
  end
endmodule : irq_host_model

/* File: tb/tb.sv */
// Self-checking testbench of the two-line interrupt controller.
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"
module tb;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, boot = 1'b0, send = 1'b0;
  logic tdone = 1'b0, terr = 1'b0, outl = 1'b0, sreq = 1'b0, sbusy = 1'b0;
  logic trig = 1'b0, hib = 1'b0, pol_m = 1'b0, blk, line0, line1, seq_start, wake, l0, l1;
  logic [15:0] addr = 16'h0000, lfsr_s = 16'h0043, edges, e0;
  logic [31:0] wdata = 32'h0, tdata = 32'h0, rdata, v, sm = `SOURCE_MASK;
  logic [8:0] meas = 9'h000;
  logic [4:0] fifo = 5'h00;
  logic [7:0] ext_in = 8'h00, ext_irq, pin_out, pin_oe;
  logic [1:0] rf, rs;
  int n_fail = 0, checks = 0, pf = 0, ps = 4, d, cnt, wk, hit;

  two_line_interrupt_controller u_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .MEAS_EVENTS(meas), .BOOT_DONE(boot), .SEQ_END(send),
    .TMO_DONE(tdone), .TMO_ERR(terr), .FIFO_EVENTS(fifo), .OUTLIER(outl), .SEQ_REQ(sreq),
    .SEQ_BUSY(sbusy), .SEQ_TRIG_WR(trig), .SEQ_TRIG_DATA(tdata), .SEQ_START(seq_start),
    .EXT_IN(ext_in), .HIBERNATE(hib), .EXT_IRQ(ext_irq), .WAKE(wake),
    .IRQ_LINE_FIRST(line0), .IRQ_LINE_SECOND(line1), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

  irq_host_model u_host (.clk(clk), .rst(rst), .pin(pin_out[pf]), .pol(pol_m), .edges(edges));

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Pin that the first line must reach for a given route code.
  function automatic int first_pin(input logic [1:0] r);
    return (r == 2'h1) ? `PIN_FIRST_A : (r == 2'h2) ? `PIN_FIRST_B : `PIN_FIRST_C;
  endfunction : first_pin

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task wr_reg(input logic [15:0] a, input logic [31:0] dat);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk

  // Each source bit of the word drives the event input that feeds the same flag position.
  task drive_src(input logic [31:0] s);
    meas <= s[8:0];
    boot <= s[13];
    send <= s[15];
    tdone <= s[16];
    terr <= s[17];
    fifo <= s[27:23];
    outl <= s[29];
    trig <= |s[12:9];
    tdata <= s;
    sreq <= s[31];
    sbusy <= s[31];
  endtask : drive_src

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OFS_POLARITY, 32'h0);
    rd_chk(`OFS_ENABLE0, `RST_ENABLE);
    rd_chk(`OFS_ENABLE1, `RST_ENABLE);
    rd_chk(`OFS_FLAGS1, 32'h0);
    rd_chk(`OFS_CUSTOM, `RST_CUSTOM);
    wr_reg(`OFS_CUSTOM, 32'hFFFF_FFFF);
    rd_chk(`OFS_CUSTOM, `RST_CUSTOM);
    wr_reg(`OFS_ENABLE0, 32'hFFFF_FFFF);
    rd_chk(`OFS_ENABLE0, `SOURCE_MASK);
    rd_chk(`OFS_CLEAR, 32'h0);
    rd_chk(16'h3030, 32'h0);
    chk({23'h0, line0, pin_oe}, 32'h100);
    for (int b = 0; b < 32; b++)
    begin
      if (sm[b])
      begin
        lfsr_s = lfsr(lfsr_s);
        v = 32'h1 << b;
        // Flags 0 and 31 always go to the first block so its checks see them.
        blk = (b == 0 || b == 31) ? 1'b0 : lfsr_s[0];
        pol_m = lfsr_s[1];
        rf = (lfsr_s[3:2] == 2'h0) ? 2'h1 : lfsr_s[3:2];
        rs = {1'b0, lfsr_s[4]} + 2'h1;
        pf = first_pin(rf);
        ps = (rs == 2'h1) ? `PIN_SECOND_A : `PIN_SECOND_B;
        wr_reg(`OFS_ROUTE, {28'h0, rs, rf});
        rd_chk(`OFS_ROUTE, {28'h0, rs, rf});
        wr_reg(`OFS_POLARITY, {31'h0, pol_m});
        wr_reg(blk ? `OFS_ENABLE1 : `OFS_ENABLE0, v);
        wr_reg(blk ? `OFS_ENABLE0 : `OFS_ENABLE1, 32'h0);
        repeat (3) @(posedge clk);
        e0 = edges;
        drive_src(v);
        @(posedge clk);
        drive_src(32'h0);
        repeat (3) @(posedge clk);
        #1;
        l0 = blk ? ~pol_m : pol_m;
        l1 = blk ? pol_m : ~pol_m;
        chk({24'h0, pin_oe}, (32'h1 << pf) | (32'h1 << ps));
        chk({28'h0, line0, line1, pin_out[pf], pin_out[ps]}, {28'h0, l0, l1, l0, l1});
        chk({16'h0, edges - e0}, {31'h0, ~blk});
        rd_chk(blk ? `OFS_FLAGS1 : `OFS_FLAGS0, v);
        rd_chk(blk ? `OFS_FLAGS0 : `OFS_FLAGS1, 32'h0);
        wr_reg(`OFS_CLEAR, ~v);
        rd_chk(blk ? `OFS_FLAGS1 : `OFS_FLAGS0, v);
        wr_reg(`OFS_CLEAR, v);
        rd_chk(blk ? `OFS_FLAGS1 : `OFS_FLAGS0, 32'h0);
        chk({30'h0, line0, line1}, {30'h0, ~pol_m, ~pol_m});
      end
    end
    // A request while idle must start a sequence and leave the collision flag clear.
    @(posedge clk);
    sreq <= 1'b1;
    @(posedge clk);
    sreq <= 1'b0;
    #1 chk({31'h0, seq_start}, 32'h1);
    rd_chk(blk ? `OFS_FLAGS1 : `OFS_FLAGS0, 32'h0);
    // Every custom source fired once and the record is never cleared by the bus.
    rd_chk(`OFS_CUSTOM, `RST_CUSTOM | 32'h0000_1E00);
    // An event and its clear in the same cycle must leave the flag set.
    wr_reg(`OFS_ENABLE0, 32'h0000_2000);
    @(posedge clk);
    wr <= 1'b1;
    addr <= `OFS_CLEAR;
    wdata <= 32'h0000_2000;
    boot <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    boot <= 1'b0;
    rd_chk(`OFS_FLAGS0, 32'h0000_2000);
    wr_reg(`OFS_CLEAR, 32'h0000_2000);
    rd_chk(`OFS_FLAGS0, 32'h0);
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk);
      lfsr_s = lfsr(lfsr_s);
      // Detector 0 in rise mode and detector 1 in high mode are fixed corner cases.
      d = (m == 0) ? 0 : (m == 3) ? 1 : int'(lfsr_s[2:0]);
      hib <= (m != 2);
      ext_in <= {lfsr_s[10:4], 1'b0} << d;
      wr_reg(d < 4 ? `OFS_EXTCFG_LO : `OFS_EXTCFG_HI, (32'h1 << m) << (8 * d[1:0]));
      wr_reg(d < 4 ? `OFS_EXTCFG_HI : `OFS_EXTCFG_LO, 32'h0);
      repeat (6) @(posedge clk);
      for (int ph = 0; ph < 2; ph++)
      begin
        ext_in[d] <= (ph == 0);
        cnt = 0;
        wk = 0;
        repeat (8)
        begin
          @(posedge clk);
          #1;
          cnt += ext_irq[d];
          wk += wake;
        end
        hit = (m == 0 && ph == 0) || (m == 1 && ph == 1) || m == 2 || m > 2;
        if (m < 3)
          chk({ext_irq[d], 31'(cnt)}, {1'b0, 31'(hit)});
        else
          chk({31'h0, ext_irq[d]}, {31'h0, (m == 3) == (ph == 0)});
        chk({31'h0, wk != 0}, {31'h0, hit != 0 && m != 2});
      end
      wr_reg(`OFS_EXTCFG_LO, 32'h0);
      wr_reg(`OFS_EXTCFG_HI, 32'h0);
    end
    close_out();
  end
endmodule : tb
